// ### dfs_afp_model.sv
/* analog processor model: scans stim at each tick, ends the pass late.
   assumes afp_start is a one-cycle pulse. */
`timescale 1ns/1ps
module dfs_afp_model
  import dfs_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              afp_start,
  input  wire logic              slow,
  input  wire logic [NIN-1:0]    stim,
  output logic      [NIN-1:0]    dig_in,
  output logic      [NALARM-1:0] alarm_in,
  output logic                   afp_done
);
  logic [5:0] wait_cnt;
  // inputs move only at the tick, so a pass never sees half a scan
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      dig_in   <= '0;
      alarm_in <= '0;
      wait_cnt <= '0;
      afp_done <= 1'b0;
    end else begin
      afp_done <= (wait_cnt == 6'h1);
      if (afp_start) begin
        dig_in   <= stim;
        alarm_in <= {stim, ~stim};
        wait_cnt <= slow ? 6'h14 : 6'h4;
      end else if (wait_cnt != 6'h0) begin
        wait_cnt <= wait_cnt - 6'h1;
      end
    end
  end
endmodule

// ### dfs_asserts.sv
/* port checks for dfs_top, bound below.
   assumes mclk only, reset async active high. */
`timescale 1ns/1ps
module dfs_asserts
  import dfs_pkg::*;
#(
  parameter int unsigned TICK_CYC = ANA_TICK_CYC
) (
  input wire logic            mclk,
  input wire logic            reset,
  input wire logic            bus_a_req,
  input wire logic            bus_b_req,
  input wire logic            afp_start,
  input wire logic [6:0]      task_grant,
  input wire logic [NOUT-1:0] dig_out,
  input wire dfs_axfer_s      ana_xfer
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  property p_hot; $onehot0(task_grant); endproperty
  a_hot: assert property (p_hot) else $error("grant not one-hot");
  property p_bus_a; task_grant[3] |-> $past(bus_a_req); endproperty
  a_bus_a: assert property (p_bus_a) else $error("bus a grant");
  property p_bus_b;
    task_grant[4] |-> $past(bus_b_req) && !$past(bus_a_req); endproperty
  a_bus_b: assert property (p_bus_b) else $error("bus b grant");
  property p_tick; afp_start |=> !afp_start [*8]; endproperty
  a_tick: assert property (p_tick) else $error("tick spacing");
  property p_afp; afp_start |-> ##[0:2] task_grant[0]; endproperty
  a_afp: assert property (p_afp) else $error("analog not first");
  property p_mt; ana_xfer.valid |-> !task_grant[1]; endproperty
  a_mt: assert property (p_mt) else $error("transfer in pass");
  property p_len; $rose(task_grant[1]) |-> task_grant[1] [*4]; endproperty
  a_len: assert property (p_len) else $error("pass too short");
  property p_out; $changed(dig_out) |-> $past(task_grant[1]); endproperty
  a_out: assert property (p_out) else $error("outputs off pass");
endmodule
bind dfs_top dfs_asserts #(.TICK_CYC(TICK_CYC)) chk_u (.mclk(mclk),
  .reset(reset), .bus_a_req(bus_a_req), .bus_b_req(bus_b_req),
  .afp_start(afp_start), .task_grant(task_grant), .dig_out(dig_out),
  .ana_xfer(ana_xfer));

// ### dfs_pkg.sv
/*
  Package for the digital function sequencer: timing constants, table sizes,
  algorithm codes, register map, packed field layouts and the whole state
  record of the sequencer.
  Assumes a single 40 MHz clock and an APB register bus with 32-bit data.
*/
package dfs_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned ANA_PERIOD_NS  = 200_000_000;   // analog pass
  localparam int unsigned DIG_PERIOD_NS  = 1_000_000_000; // digital pass
  localparam int unsigned ANA_TICK_CYC   = ANA_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = 23;
  localparam logic [2:0]  TICKS_PER_PASS = 3'(DIG_PERIOD_NS / ANA_PERIOD_NS);

  // table sizes
  localparam int unsigned NLINES = 150;
  localparam int unsigned NNODES = 192;
  localparam int unsigned NIN    = 32;
  localparam int unsigned NOUT   = 32;
  localparam int unsigned NTAB   = 36;
  localparam int unsigned NENT   = 20;
  localparam int unsigned NALARM = 64;
  localparam logic [15:0] PRESET_MAX  = 16'hfffe;
  localparam logic [5:0]  PWRUP_TABLE = 6'h02;

  // algorithm codes
  localparam logic [3:0] ALG_NOP   = 4'h0;
  localparam logic [3:0] ALG_AND   = 4'h1;
  localparam logic [3:0] ALG_OR    = 4'h2;
  localparam logic [3:0] ALG_TAND  = 4'h3;
  localparam logic [3:0] ALG_TOR   = 4'h4;
  localparam logic [3:0] ALG_MTAND = 4'h5;
  localparam logic [3:0] ALG_MTOR  = 4'h6;
  localparam logic [3:0] ALG_JAND  = 4'h7;
  localparam logic [3:0] ALG_JOR   = 4'h8;
  localparam logic [3:0] ALG_TIMER = 4'h9;
  localparam logic [3:0] ALG_COUNT = 4'ha;
  localparam logic [3:0] ALG_PULSE = 4'hb;
  localparam logic [3:0] ALG_ALARM = 4'hc;

  // mode transfer actions
  localparam logic [2:0] MT_ACT_HOLD  = 3'h1;
  localparam logic [2:0] MT_ACT_AUTO  = 3'h2;
  localparam logic [2:0] MT_ACT_SEL   = 3'h3;
  localparam logic [2:0] MT_ACT_AUTSP = 3'h4; // analog only

  // executive grant bit positions, highest priority first
  localparam int unsigned GR_AFP   = 0;
  localparam int unsigned GR_DFP   = 1;
  localparam int unsigned GR_MT    = 2;
  localparam int unsigned GR_BUSA  = 3;
  localparam int unsigned GR_BUSB  = 4;
  localparam int unsigned GR_XSIDE = 5;
  localparam int unsigned GR_DIAG  = 6;

  // register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_LINE_SEL = 8'h08;
  localparam logic [7:0] REG_LINE_W0  = 8'h0c;
  localparam logic [7:0] REG_LINE_W1  = 8'h10;
  localparam logic [7:0] REG_LINE_W2  = 8'h14;
  localparam logic [7:0] REG_MT_SEL   = 8'h18;
  localparam logic [7:0] REG_MT_DATA  = 8'h1c;
  localparam logic [7:0] REG_DIG_OUT  = 8'h20;

  // configuration word 1 layout
  typedef struct packed {
    logic [3:0] rsv;
    logic       inv_out;
    logic [4:0] inv_in;
    logic       man_val;
    logic       manual;
    logic [3:0] code;
    logic [7:0] out_idx;
    logic [7:0] in5_idx;
  } dfs_lw1_s;

  typedef struct packed {
    logic [15:0]     aux;   // preset, skip count, table, 2nd out, alarm
    dfs_lw1_s        w1;
    logic [3:0][7:0] in_lo; // input node indices 1 to 4
  } dfs_line_s;

  // mode transfer entry, low bits of the data word
  typedef struct packed {
    logic       valid;
    logic       analog;
    logic       value;
    logic [2:0] act;
    logic [7:0] line;
  } dfs_mte_s;

  typedef struct packed {
    logic       valid;
    logic [2:0] act;
    logic [7:0] line;
    logic       value;
  } dfs_axfer_s;

  typedef struct packed {
    logic [15:0] pass_cnt;
    logic [4:0]  rsv;
    logic        dp_busy;
    logic        mt_any;
    logic        afp_pend;
    logic        dfp_pend;
    logic [6:0]  grant;
  } dfs_status_s;

  typedef enum logic [1:0] {DP_IDLE, DP_UNPACK, DP_LINES, DP_PACK} dfs_dp_e;

  typedef struct packed {
    dfs_line_s [NLINES-1:0]      line;
    dfs_mte_s [NTAB*NENT-1:0]    mte;
    logic [NLINES-1:0][15:0]     acc;
    logic [NLINES-1:0]           prev;
    logic [NNODES-1:0]           node;
    logic [NTAB-1:0]             mt_pend;
    dfs_dp_e                     dp;
    logic [7:0]                  pc;
    logic [5:0]                  mt_tab;
    logic [4:0]                  mt_ent;
    logic [TICK_W-1:0]           tick_cnt;
    logic [2:0]                  tick_div;
    logic                        afp_pend;
    logic                        dfp_pend;
    logic                        run;
    logic [6:0]                  grant;
    logic                        afp_start;
    logic [NOUT-1:0]             dig_out;
    dfs_axfer_s                  ana_xfer;
    logic [15:0]                 pass_cnt;
    logic [7:0]                  line_sel;
    logic [5:0]                  mt_tsel;
    logic [4:0]                  mt_esel;
    logic                        pready;
    logic                        pslverr;
    logic [31:0]                 prdata;
  } dfs_state_s;

endpackage

// ### dfs_top.sv
/*
  Digital function sequencer: executive, once-per-second pass over the
  configuration lines, node table, mode transfer tables, APB registers.
  Assumes dig_in, alarm_in, afp_done and the task requests come from logic
  on mclk; the analog processor starts on afp_start and ends with afp_done.
*/
// The address map and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps

module dfs_top
  import dfs_pkg::*;
#(
  parameter int unsigned TICK_CYC = ANA_TICK_CYC
) (
  input  wire logic              mclk,
  input  wire logic              reset,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [NIN-1:0]    dig_in,
  input  wire logic [NALARM-1:0] alarm_in,
  input  wire logic              afp_done,
  input  wire logic              bus_a_req,
  input  wire logic              bus_b_req,
  input  wire logic              xside_req,
  output logic                   afp_start,
  output logic      [6:0]        task_grant,
  output logic      [NOUT-1:0]   dig_out,
  output dfs_axfer_s             ana_xfer
);

  dfs_state_s  st_ff;
  dfs_state_s  nxt_st;
  dfs_line_s   ln;
  dfs_mte_s    me;
  dfs_status_s stat;
  logic [7:0]  li;
  logic [4:0]  x;
  logic        z_sel;
  logic        has_out;
  logic        tick;
  logic [6:0]  req;
  logic [15:0] acc;
  logic [15:0] nacc;
  logic [16:0] nxt_pc_w;
  logic [16:0] skip;
  logic [5:0]  tab;
  logic [9:0]  mi;
  logic [9:0]  mi_sel;
  logic        line_ok;
  logic        mt_ok;
  logic        run_or_count_input;
  logic        clear_input;
  logic        freeze_input;

  // out-of-range node indices read as zero
  function automatic logic node_rd(input logic [NNODES-1:0] nv,
                                   input logic [7:0]        idx);
    node_rd = (idx < NNODES) ? nv[idx] : 1'b0;
  endfunction

  // writes to nonexistent nodes are dropped
  function automatic logic [NNODES-1:0] node_wr(
      input logic [NNODES-1:0] nv,
      input logic [7:0]        idx,
      input logic              v);
    node_wr = nv;
    if (idx < NNODES) begin
      node_wr[idx] = v;
    end
  endfunction

  // outputs come straight from the state register
  assign prdata     = st_ff.prdata;
  assign pready     = st_ff.pready;
  assign pslverr    = st_ff.pslverr;
  assign afp_start  = st_ff.afp_start;
  assign task_grant = st_ff.grant;
  assign dig_out    = st_ff.dig_out;
  assign ana_xfer   = st_ff.ana_xfer;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.afp_start = 1'b0;
    nxt_st.ana_xfer.valid = 1'b0;
    nxt_st.pready = 1'b0;
    nxt_st.pslverr = 1'b0;
    tick = 1'b0;

    // analog timebase; digital pass every fifth analog tick
    if (st_ff.run) begin
      if (st_ff.tick_cnt == TICK_W'(TICK_CYC - 1)) begin
        nxt_st.tick_cnt = '0;
        tick = 1'b1;
      end else begin
        nxt_st.tick_cnt = st_ff.tick_cnt + 1'b1;
      end
    end
    if (tick) begin
      nxt_st.afp_start = 1'b1;
      nxt_st.afp_pend = 1'b1;  // set beats a same-cycle done
      if (st_ff.tick_div == TICKS_PER_PASS - 3'h1) begin
        nxt_st.tick_div = 3'h0;
        nxt_st.dfp_pend = 1'b1;
      end else begin
        nxt_st.tick_div = st_ff.tick_div + 3'h1;
      end
    end else if (afp_done) begin
      nxt_st.afp_pend = 1'b0;
    end

    // executive: lowest set request bit wins, diagnostics soak idle time
    req = {st_ff.run, xside_req & st_ff.run, bus_b_req & st_ff.run,
           bus_a_req & st_ff.run, (|st_ff.mt_pend) & st_ff.run,
           st_ff.dfp_pend, st_ff.afp_pend};
    nxt_st.grant = req & (~req + 7'h01);

    // current line fetch, guarded so a parked pc never indexes past the end
    li = (st_ff.pc < NLINES) ? st_ff.pc : 8'h00;
    ln = st_ff.line[li];
    for (int k = 0; k < 5; k++) begin
      x[k] = node_rd(st_ff.node, (k < 4) ? ln.in_lo[k[1:0]] : ln.w1.in5_idx)
             ^ ln.w1.inv_in[k];
    end
    z_sel = ln.w1.code[0] ? (&x) : (|x); // odd gate codes are AND
    run_or_count_input = x[0];
    clear_input = x[1];
    freeze_input = x[2];
    acc = st_ff.acc[li];
    nacc = acc;
    skip = '0;
    tab = 6'(ln.aux - 16'h0001);
    has_out = (ln.w1.code != ALG_NOP) && (ln.w1.code != ALG_MTAND) &&
              (ln.w1.code != ALG_MTOR) && (ln.w1.code != ALG_JAND) &&
              (ln.w1.code != ALG_JOR);
    nxt_pc_w = 17'(st_ff.pc) + 17'h00001;

    // digital pass; only steps while the executive grants it
    case (st_ff.dp)
      DP_IDLE: begin
        if (st_ff.dfp_pend && st_ff.grant[GR_DFP]) begin
          nxt_st.dp = DP_UNPACK;
        end
      end
      DP_UNPACK: begin
        if (st_ff.grant[GR_DFP]) begin
          nxt_st.node[NIN-1:0] = dig_in;
          nxt_st.pc = 8'h00;
          nxt_st.dp = DP_LINES;
        end
      end
      DP_LINES: begin
        if (st_ff.grant[GR_DFP] && st_ff.pc >= NLINES) begin
          nxt_st.dp = DP_PACK;
        end else if (st_ff.grant[GR_DFP]) begin
          if (ln.w1.manual) begin
            if (has_out) begin
              nxt_st.node = node_wr(st_ff.node, ln.w1.out_idx,
                                    ln.w1.man_val);
            end
          end else begin
            case (ln.w1.code)
              ALG_AND, ALG_OR: begin
                nxt_st.node = node_wr(st_ff.node, ln.w1.out_idx,
                                      z_sel ^ ln.w1.inv_out);
              end
              ALG_TAND, ALG_TOR: begin
                // latched: only another line can drop it again
                if (z_sel) begin
                  nxt_st.node = node_wr(st_ff.node, ln.w1.out_idx,
                                        ~ln.w1.inv_out);
                end
              end
              ALG_MTAND, ALG_MTOR: begin
                nxt_st.prev[li] = z_sel;
                if (z_sel && !st_ff.prev[li] && ln.aux != 16'h0000 &&
                    ln.aux <= NTAB) begin
                  nxt_st.mt_pend[tab] = 1'b1;
                end
              end
              ALG_JAND, ALG_JOR: begin
                nxt_st.prev[li] = z_sel;
                if (z_sel && !st_ff.prev[li]) begin
                  skip = 17'(ln.aux);
                end
              end
              ALG_TIMER: begin
                if (clear_input) begin
                  nacc = 16'h0000;
                end else if (!freeze_input && run_or_count_input &&
                             acc < ln.aux) begin
                  nacc = acc + 16'h0001;
                end
                nxt_st.acc[li] = nacc;
                nxt_st.node = node_wr(st_ff.node, ln.w1.out_idx,
                    (ln.aux != 16'h0000 && nacc >= ln.aux)
                    ^ ln.w1.inv_out);
              end
              ALG_COUNT: begin
                nxt_st.prev[li] = run_or_count_input;
                if (clear_input) begin
                  nacc = 16'h0000;
                end else if (!freeze_input && run_or_count_input &&
                             !st_ff.prev[li] && acc < ln.aux) begin
                  nacc = acc + 16'h0001;
                end
                nxt_st.acc[li] = nacc;
                nxt_st.node = node_wr(st_ff.node, ln.w1.out_idx,
                    (ln.aux != 16'h0000 && nacc >= ln.aux)
                    ^ ln.w1.inv_out);
              end
              ALG_PULSE: begin
                // each output true for exactly the pass that saw the edge
                nxt_st.prev[li] = run_or_count_input;
                nxt_st.node = node_wr(
                    node_wr(st_ff.node, ln.w1.out_idx,
                            (run_or_count_input & ~st_ff.prev[li])
                            ^ ln.w1.inv_out),
                    ln.aux[7:0],
                    (~run_or_count_input & st_ff.prev[li])
                    ^ ln.w1.inv_out);
              end
              ALG_ALARM: begin
                nxt_st.node = node_wr(st_ff.node, ln.w1.out_idx,
                    ((ln.aux < NALARM) ? alarm_in[ln.aux[5:0]] : 1'b0)
                    ^ ln.w1.inv_out);
              end
              default: begin
              end
            endcase
          end
          // next line in order, jumps land past the skipped lines
          nxt_pc_w = nxt_pc_w + skip;
          nxt_st.pc = (nxt_pc_w >= 17'(NLINES)) ? 8'(NLINES) : nxt_pc_w[7:0];
        end
      end
      DP_PACK: begin
        if (st_ff.grant[GR_DFP]) begin
          nxt_st.dig_out = st_ff.node[NIN+NOUT-1:NIN];
          nxt_st.dfp_pend = 1'b0;
          nxt_st.pass_cnt = st_ff.pass_cnt + 16'h0001;
          nxt_st.dp = DP_IDLE;
        end
      end
      default: begin
        nxt_st.dp = DP_IDLE;
      end
    endcase

    // mode transfer walk; granted only with both passes finished
    mi = 10'((st_ff.mt_tab * NENT) + st_ff.mt_ent);
    me = st_ff.mte[mi];
    if (st_ff.grant[GR_MT] && !st_ff.afp_pend &&
        !st_ff.dfp_pend) begin
      if (st_ff.mt_pend[st_ff.mt_tab] && me.valid) begin
        if (me.analog) begin
          nxt_st.ana_xfer = '{1'b1, me.act, me.line, me.value};
        end else if (me.line < NLINES) begin
          case (me.act)
            MT_ACT_HOLD: begin
              nxt_st.line[me.line].w1.manual = 1'b1;
              nxt_st.line[me.line].w1.man_val =
                  node_rd(st_ff.node, st_ff.line[me.line].w1.out_idx);
            end
            MT_ACT_AUTO: begin
              nxt_st.line[me.line].w1.manual = 1'b0;
            end
            MT_ACT_SEL: begin
              nxt_st.line[me.line].w1.manual = 1'b1;
              nxt_st.line[me.line].w1.man_val = me.value;
            end
            default: begin
            end
          endcase
        end
      end
      // idle tables are passed over in one cycle
      if (!st_ff.mt_pend[st_ff.mt_tab] ||
          st_ff.mt_ent == 5'(NENT - 1)) begin
        nxt_st.mt_pend[st_ff.mt_tab] = 1'b0;
        nxt_st.mt_ent = 5'h00;
        nxt_st.mt_tab = (st_ff.mt_tab == 6'(NTAB - 1)) ? 6'h00
                      : st_ff.mt_tab + 6'h01;
      end else begin
        nxt_st.mt_ent = st_ff.mt_ent + 5'h01;
      end
    end else begin
      // restart after preemption; repeated entries are idempotent
      nxt_st.mt_tab = 6'h00;
      nxt_st.mt_ent = 5'h00;
    end

    // register access helpers
    line_ok = st_ff.line_sel < NLINES;
    mt_ok = (st_ff.mt_tsel != 6'h00) && (st_ff.mt_tsel <= NTAB) &&
            (st_ff.mt_esel < NENT);
    mi_sel = 10'(((st_ff.mt_tsel - 6'h01) * NENT) + st_ff.mt_esel);
    stat = '{pass_cnt: st_ff.pass_cnt, rsv: 5'h00,
             dp_busy: st_ff.dp != DP_IDLE, mt_any: |st_ff.mt_pend,
             afp_pend: st_ff.afp_pend, dfp_pend: st_ff.dfp_pend,
             grant: st_ff.grant};

    // apb: one wait state, answer registered in the first access cycle
    if (psel && penable && !st_ff.pready) begin
      nxt_st.pready = 1'b1;
      nxt_st.prdata = 32'h00000000;
      if (paddr == REG_CTRL) begin
        nxt_st.prdata = {31'h00000000, st_ff.run};
      end else if (paddr == REG_STATUS) begin
        nxt_st.prdata = stat;
      end else if (paddr == REG_LINE_SEL) begin
        nxt_st.prdata = {24'h000000, st_ff.line_sel};
      end else if (paddr == REG_LINE_W0) begin
        nxt_st.prdata = line_ok ? st_ff.line[st_ff.line_sel].in_lo : 32'h0;
      end else if (paddr == REG_LINE_W1) begin
        nxt_st.prdata = line_ok ? st_ff.line[st_ff.line_sel].w1 : 32'h0;
      end else if (paddr == REG_LINE_W2) begin
        nxt_st.prdata = line_ok ? {st_ff.acc[st_ff.line_sel],
                                   st_ff.line[st_ff.line_sel].aux}
                                : 32'h00000000;
      end else if (paddr == REG_MT_SEL) begin
        nxt_st.prdata = {19'h00000, st_ff.mt_esel, 2'h0, st_ff.mt_tsel};
      end else if (paddr == REG_MT_DATA) begin
        nxt_st.prdata = mt_ok ? {18'h00000, st_ff.mte[mi_sel]} : 32'h0;
      end else if (paddr == REG_DIG_OUT) begin
        nxt_st.prdata = st_ff.dig_out;
      end else begin
        nxt_st.pslverr = 1'b1;
      end
    end

    // writes land at the completing edge, after any table walk update
    if (psel && penable && st_ff.pready && pwrite) begin
      if (paddr == REG_CTRL) begin
        nxt_st.run = pwdata[0];
      end else if (paddr == REG_LINE_SEL) begin
        nxt_st.line_sel = pwdata[7:0];
      end else if (paddr == REG_LINE_W0 && line_ok) begin
        nxt_st.line[st_ff.line_sel].in_lo = pwdata;
      end else if (paddr == REG_LINE_W1 && line_ok) begin
        nxt_st.line[st_ff.line_sel].w1 = dfs_lw1_s'(pwdata);
      end else if (paddr == REG_LINE_W2 && line_ok) begin
        nxt_st.line[st_ff.line_sel].aux =
            (pwdata[15:0] > PRESET_MAX) ? PRESET_MAX : pwdata[15:0];
      end else if (paddr == REG_MT_SEL) begin
        nxt_st.mt_tsel = pwdata[5:0];
        nxt_st.mt_esel = pwdata[12:8];
      end else if (paddr == REG_MT_DATA && mt_ok) begin
        nxt_st.mte[mi_sel] = dfs_mte_s'(pwdata[13:0]);
      end
    end
  end

  // power-up table waits pending until software starts the sequencer
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      st_ff <= '0;
      st_ff.mt_pend[PWRUP_TABLE - 6'h01] <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule

// ### testbench.sv
/* bench: registers, random passes, mode transfer.
   assumes dfs_afp_model on the far side. */
`timescale 1ns/1ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("wrong value at %0t: %s", $time, m); end end
module testbench;
  import dfs_pkg::*;
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic bus_a_req = 0, bus_b_req = 0, xside_req = 0, pready, pslverr, e;
  logic afp_start, afp_done, pa = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q, stim = 0;
  logic [NIN-1:0] dig_in;
  logic [NALARM-1:0] alarm_in;
  logic [6:0] task_grant;
  logic [NOUT-1:0] dig_out;
  dfs_axfer_s ana_xfer, ax;
  logic [15:0] lf = 16'h114a;
  logic [3:0] s, x;
  logic [3:0] corner [4] = '{4'h9, 4'h8, 4'h5, 4'h2};
  int fails = 0, cmp_count = 0, cnt = 0, tmr = 0, ticks = 0;
  always #12.5 mclk = ~mclk;
  always @(posedge mclk) if (afp_start === 1'b1) ticks++;
  // last analog mode transfer seen on the far side
  always @(posedge mclk) if (ana_xfer.valid === 1'b1) ax = ana_xfer;
  dfs_top #(.TICK_CYC(200)) dut_u (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .dig_in(dig_in),
    .alarm_in(alarm_in), .afp_done(afp_done), .bus_a_req(bus_a_req),
    .bus_b_req(bus_b_req), .xside_req(xside_req), .afp_start(afp_start),
    .task_grant(task_grant), .dig_out(dig_out), .ana_xfer(ana_xfer));
  dfs_afp_model afp_u (.mclk(mclk), .reset(reset), .afp_start(afp_start),
    .slow(slow), .stim(stim), .dig_in(dig_in), .alarm_in(alarm_in),
    .afp_done(afp_done));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // expected counter, timer, rise and fall pulse outputs
  function automatic logic [3:0] model(input logic [3:0] v);
    if (v[1]) cnt = 0;
    else if (!v[2] && v[0] && !pa && cnt < 3) cnt++;
    if (v[1]) tmr = 0;
    else if (v[3] && !v[2] && tmr < 2) tmr++;
    model = {!v[0] && pa, v[0] && !pa, 1'(tmr >= 2), 1'(cnt >= 3)};
    pa = v[0];
  endfunction
  // one apb transfer, held until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic cfg(input logic [7:0] n, input logic [31:0] w0, w1, aux);
    wr(REG_LINE_SEL, {24'h0, n});
    wr(REG_LINE_W0, w0);
    wr(REG_LINE_W1, w1);
    wr(REG_LINE_W2, aux);
  endtask
  // waits for one digital pass to start and finish
  task automatic pass_end;
    int n = 0;
    while (task_grant[1] !== 1'b1 && n++ < 9999) @(posedge mclk);
    if (n > 9999) fails++;
    `CHK(ticks, 5, "ticks per pass")
    ticks = 0;
    while (task_grant[1] === 1'b1) @(posedge mclk);
    repeat (2) @(posedge mclk);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    rd(8'h24);
    `CHK(e, 1'b1, "unmapped")
    wr(REG_MT_SEL, 32'h25);
    wr(REG_MT_DATA, 32'h2b04);
    rd(REG_MT_DATA);
    `CHK(q, 32'h0, "table 37")
    wr(REG_MT_SEL, 32'h1403);
    wr(REG_MT_DATA, 32'h2b04);
    rd(REG_MT_DATA);
    `CHK(q, 32'h0, "entry 20")
    wr(REG_MT_SEL, 32'h103);
    wr(REG_MT_DATA, 32'h3207);
    wr(REG_MT_SEL, 32'h3);
    wr(REG_MT_DATA, 32'h2b04);
    rd(REG_MT_DATA);
    `CHK(q, 32'h2b04, "entry back")
    wr(REG_MT_SEL, 32'h2);
    wr(REG_MT_DATA, 32'h2b05);
    $display("register test done");
    cfg(8'h0, 32'h00020100, 32'h000a2000, 32'h3);
    cfg(8'h1, 32'h00020103, 32'h00092100, 32'h2);
    cfg(8'h2, 32'h0, 32'h000b2200, 32'h23);
    cfg(8'h3, 32'h04040404, 32'h00064004, 32'h3);
    cfg(8'h4, 32'h05050505, 32'h00012405, 32'h0);
    cfg(8'h5, 32'h05050505, 32'h00012505, 32'h0);
    cfg(8'h6, 32'h0, 32'h000c2600, 32'h0);
    wr(REG_CTRL, 32'h1);
    // corners first, then clear and freeze made rarer than count
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      s = (i < 4) ? corner[i] : {lf[3], lf[2] & lf[9], lf[1] & lf[8], lf[0]};
      stim <= {28'h0, s};
      slow <= lf[4];
      bus_a_req <= lf[5];
      bus_b_req <= lf[6];
      xside_req <= lf[11];
      x = model(s);
      pass_end;
      `CHK(dig_out[5:0], {2'b10, x}, "pass outputs")
      `CHK(dig_out[6], ~s[0], "alarm bit")
    end
    wr(REG_LINE_SEL, 32'h0);
    rd(REG_LINE_W2);
    `CHK(q, {16'(cnt), 16'h3}, "count value")
    $display("random pass test done");
    stim <= 32'h10;
    pass_end;
    `CHK(dig_out[4], 1'b0, "early transfer")
    pass_end;
    `CHK(dig_out[4], 1'b1, "manual select")
    `CHK(ax, {1'b1, 3'h2, 8'h07, 1'b0}, "analog entry")
    $display("mode transfer test done");
    complete_run;
  end
  initial begin
    #1_000_000;
    fails++;
    complete_run;
  end
endmodule
